/* pcacc_top.sv */
// Conversion sequencer with current and power averaging
`include "pcacc_consts.svh"
module pcacc_top #(
    parameter int W = 16
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   run,
    input  wire logic                   en_shunt,
    input  wire logic                   en_bus,
    input  wire logic                   en_temp,
    input  wire logic [`PCACC_AVG_W-1:0] avg_count,
    input  wire logic [W-1:0]           shunt_cal,
    output logic      [1:0]             adc_sel,
    output logic                        adc_start,
    input  wire logic                   adc_done,
    input  wire logic [W-1:0]           adc_data,
    output logic signed [W-1:0]         current_out,
    output logic signed [2*W-1:0]       power_out,
    output logic [W-1:0]                shunt_out,
    output logic [W-1:0]                bus_out,
    output logic [W-1:0]                temp_out,
    output logic                        ready
);
    localparam int AW = `PCACC_AVG_W;
    localparam int SW = 2*W + AW;

    pcacc_pkg::pcacc_state_t state;
    logic                 done_q;
    logic [W-1:0]         data_q;
    logic                 run_q;
    logic [W-1:0]         shunt_s;
    logic [W-1:0]         bus_s;
    logic                 got_shunt;
    logic                 go_d1;
    logic                 go;
    logic [AW-1:0]        n;
    logic [AW-1:0]        avg_n;
    logic signed [SW-1:0] acc_i;
    logic signed [SW-1:0] acc_p;
    logic signed [W-1:0]  cur;
    logic signed [2*W-1:0] pwr;
    logic                 calc_done;
    logic                 finish;

    function automatic pcacc_pkg::pcacc_state_t first_after(
        input logic [1:0] from, input logic es, input logic eb,
        input logic et);
        if (from == `PCACC_SEL_SHUNT && eb)
            return pcacc_pkg::PCACC_BUS;
        if (from != `PCACC_SEL_TEMP && et)
            return pcacc_pkg::PCACC_TEMP;
        return pcacc_pkg::PCACC_NEXT;
    endfunction : first_after

    assign avg_n = (avg_count == '0) ? AW'(1) : avg_count;

    // Converter handshake comes from the same clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done_q <= 1'b0;
            data_q <= '0;
            run_q  <= 1'b0;
        end
        else
        begin
            done_q <= adc_done;
            data_q <= adc_data;
            run_q  <= run;
        end
    end

    // Sequencer: one input to the converter at a time
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= pcacc_pkg::PCACC_IDLE;
            adc_sel   <= `PCACC_SEL_SHUNT;
            adc_start <= 1'b0;
            got_shunt <= 1'b0;
            go        <= 1'b0;
            go_d1     <= 1'b0;
            shunt_s   <= '0;
            bus_s     <= '0;
            temp_out  <= '0;
            n         <= '0;
            finish    <= 1'b0;
        end
        else
        begin
            adc_start <= 1'b0;
            go        <= 1'b0;
            go_d1     <= go;
            finish    <= 1'b0;
            case (state)
                pcacc_pkg::PCACC_IDLE:
                begin
                    if (run_q && (en_shunt || en_bus || en_temp))
                    begin
                        n         <= '0;
                        got_shunt <= 1'b0;
                        adc_start <= 1'b1;
                        if (en_shunt)
                        begin
                            state   <= pcacc_pkg::PCACC_SHUNT;
                            adc_sel <= `PCACC_SEL_SHUNT;
                        end
                        else if (en_bus)
                        begin
                            state   <= pcacc_pkg::PCACC_BUS;
                            adc_sel <= `PCACC_SEL_BUS;
                        end
                        else
                        begin
                            state   <= pcacc_pkg::PCACC_TEMP;
                            adc_sel <= `PCACC_SEL_TEMP;
                        end
                    end
                end
                pcacc_pkg::PCACC_SHUNT,
                pcacc_pkg::PCACC_BUS,
                pcacc_pkg::PCACC_TEMP:
                begin
                    if (done_q)
                    begin
                        if (state == pcacc_pkg::PCACC_SHUNT)
                        begin
                            shunt_s   <= data_q;
                            got_shunt <= 1'b1;
                        end
                        else if (state == pcacc_pkg::PCACC_BUS)
                        begin
                            bus_s <= data_q;
                            if (got_shunt)
                            begin
                                go        <= 1'b1;
                                got_shunt <= 1'b0;
                            end
                        end
                        else
                            temp_out <= data_q;
                        // Next enabled input, in order
                        state <= first_after(adc_sel, en_shunt, en_bus,
                                             en_temp);
                        if (first_after(adc_sel, en_shunt, en_bus, en_temp)
                            == pcacc_pkg::PCACC_BUS)
                        begin
                            adc_sel   <= `PCACC_SEL_BUS;
                            adc_start <= 1'b1;
                        end
                        else if (first_after(adc_sel, en_shunt, en_bus,
                                 en_temp) == pcacc_pkg::PCACC_TEMP)
                        begin
                            adc_sel   <= `PCACC_SEL_TEMP;
                            adc_start <= 1'b1;
                        end
                    end
                end
                pcacc_pkg::PCACC_NEXT:
                begin
                    // Restart at once; finish once arithmetic has landed
                    if (n + AW'(1) < avg_n || (!go && !go_d1 && !calc_done))
                    begin
                        if (n + AW'(1) >= avg_n)
                        begin
                            finish <= 1'b1;
                            state  <= pcacc_pkg::PCACC_IDLE;
                        end
                        else
                        begin
                            n         <= n + AW'(1);
                            got_shunt <= 1'b0;
                            adc_start <= 1'b1;
                            if (en_shunt)
                            begin
                                state   <= pcacc_pkg::PCACC_SHUNT;
                                adc_sel <= `PCACC_SEL_SHUNT;
                            end
                            else if (en_bus)
                            begin
                                state   <= pcacc_pkg::PCACC_BUS;
                                adc_sel <= `PCACC_SEL_BUS;
                            end
                            else
                            begin
                                state   <= pcacc_pkg::PCACC_TEMP;
                                adc_sel <= `PCACC_SEL_TEMP;
                            end
                        end
                    end
                end
                default:
                    state <= pcacc_pkg::PCACC_IDLE;
            endcase
        end
    end

    // Arithmetic in parallel with the next conversion
    pcacc_calc #(.W(W)) pcacc_calc_i (
        .clk     (clk),
        .rst     (rst),
        .go      (go),
        .shunt   ($signed(shunt_s)),
        .vbus    (bus_s),
        .cal     (shunt_cal),
        .current (cur),
        .power   (pwr),
        .done    (calc_done)
    );

    // Accumulator and output loading
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_i       <= '0;
            acc_p       <= '0;
            current_out <= '0;
            power_out   <= '0;
            shunt_out   <= '0;
            bus_out     <= '0;
            ready       <= 1'b0;
        end
        else
        begin
            ready <= finish;
            if (state == pcacc_pkg::PCACC_IDLE && run_q)
            begin
                acc_i <= '0;
                acc_p <= '0;
            end
            if (calc_done)
            begin
                acc_i <= acc_i + SW'(cur);
                acc_p <= acc_p + SW'(pwr);
            end
            if (finish)
            begin
                // Averages loaded only when every sample is done
                current_out <= W'(acc_i / $signed({1'b0, avg_n}));
                power_out   <= (2*W)'(acc_p / $signed({1'b0, avg_n}));
                shunt_out   <= shunt_s;
                bus_out     <= bus_s;
            end
        end
    end

    a_power_zero: assert property (
        @(posedge clk) disable iff (rst)
        $rose(calc_done) && shunt_cal == '0 |-> pwr == '0)
        else $error("power not zero with zero calibration");
    a_calc_after_bus: assert property (
        @(posedge clk) disable iff (rst)
        go |-> $past(state) == pcacc_pkg::PCACC_BUS)
        else $error("calculation without bus sample");
    a_calc_latency: assert property (
        @(posedge clk) disable iff (rst)
        go |-> ##2 calc_done)
        else $error("arithmetic latency wrong");
    a_ready_follows: assert property (
        @(posedge clk) disable iff (rst)
        finish |=> ready)
        else $error("ready missing after finish");
    a_one_start: assert property (
        @(posedge clk) disable iff (rst)
        adc_start |=> !adc_start)
        else $error("back to back converter starts");
    a_sel_match: assert property (
        @(posedge clk) disable iff (rst)
        adc_start && state == pcacc_pkg::PCACC_BUS
        |-> adc_sel == `PCACC_SEL_BUS)
        else $error("bus state with wrong select");
    a_acc_adds: assert property (
        @(posedge clk) disable iff (rst)
        calc_done && !finish |=> acc_i == $past(acc_i) + SW'($past(cur)))
        else $error("accumulator did not add");
    a_no_finish_early: assert property (
        @(posedge clk) disable iff (rst)
        finish |-> n + AW'(1) >= avg_n)
        else $error("finish before all samples");
    c_finish: cover property (@(posedge clk) ready);
    c_calc: cover property (@(posedge clk) calc_done);
    c_zero_cal: cover property (@(posedge clk) calc_done && shunt_cal == '0);
endmodule : pcacc_top

/* pcacc_consts.svh */
// Constants for the power calculation and averaging engine
//
// Operation
// - Compute only after shunt and bus samples
// - Power uses the current just computed from the same sample, latest bus
// - Zero shunt calibration gives zero power
// - Accumulate intermediates at every averaging count, one included
// - Add new values after every sample
// - Load averages into output registers when done
// - Arithmetic runs beside conversions, no delay
// - One multiplexer feeds one shared converter
// - Enabled inputs converted one after another
`ifndef PCACC_CONSTS_SVH
`define PCACC_CONSTS_SVH
`define PCACC_SEL_SHUNT 2'h0
`define PCACC_SEL_BUS   2'h1
`define PCACC_SEL_TEMP  2'h2
`define PCACC_AVG_W     11
`define PCACC_CUR_SHIFT 11
`endif

/* pcacc_pkg.sv */
// Types for the power calculation and averaging engine
package pcacc_pkg;
    typedef enum logic [2:0] {
        PCACC_IDLE  = 3'b000,
        PCACC_SHUNT = 3'b001,
        PCACC_BUS   = 3'b010,
        PCACC_TEMP  = 3'b011,
        PCACC_NEXT  = 3'b100
    } pcacc_state_t;
endpackage : pcacc_pkg

/* pcacc_calc.sv */
// Background current and power arithmetic, one multiply per cycle
`include "pcacc_consts.svh"
module pcacc_calc #(
    parameter int W = 16
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                go,
    input  wire logic signed [W-1:0] shunt,
    input  wire logic        [W-1:0] vbus,
    input  wire logic        [W-1:0] cal,
    output logic signed      [W-1:0] current,
    output logic signed    [2*W-1:0] power,
    output logic                     done
);
    logic                  step2;
    logic signed [2*W:0]   prod;
    logic        [W-1:0]   vbus_hold;
    logic signed [2*W:0]   pprod;

    assign prod = shunt * $signed({1'b0, cal});
    assign pprod = current * $signed({1'b0, vbus_hold});

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            current   <= '0;
            power     <= '0;
            step2     <= 1'b0;
            done      <= 1'b0;
            vbus_hold <= '0;
        end
        else
        begin
            step2 <= go;
            done  <= step2;
            if (go)
            begin
                current   <= W'(prod >>> `PCACC_CUR_SHIFT);
                vbus_hold <= vbus;
            end
            if (step2)
            begin
                if (cal == '0)
                    power <= '0;
                else
                    power <= pprod[2*W-1:0];
            end
        end
    end
endmodule : pcacc_calc

/* pcacc_adc_model.sv */
// Behavioural shared converter answering the conversion sequencer
module pcacc_adc_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  adc_sel,
    input  wire logic        adc_start,
    input  wire logic [3:0]  lat,
    input  wire logic [15:0] shunt_v,
    input  wire logic [15:0] bus_v,
    input  wire logic [15:0] temp_v,
    output logic             adc_done,
    output logic [15:0]      adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  cnt;
    logic        busy;
    logic [15:0] val;

    // Data only valid with done, otherwise a changed pattern
    assign adc_data = adc_done ? val : ~val;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            adc_done <= 1'b0;
            val <= 16'h0;
        end
        else
        begin
            adc_done <= 1'b0;
            if (adc_start)
            begin
                busy <= 1'b1;
                cnt <= lat;
                val <= (adc_sel == 2'h0) ? shunt_v :
                       (adc_sel == 2'h1) ? bus_v : temp_v;
            end
            else if (busy && cnt == 4'h0)
            begin
                busy <= 1'b0;
                adc_done <= 1'b1;
            end
            else if (busy)
                cnt <= cnt - 4'h1;
        end
    end
endmodule : pcacc_adc_model

/* pcacc_top_tb.sv */
// Self-checking bench for the power calculation and averaging engine
module pcacc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk, rst, run, en_shunt, en_bus, en_temp;
    logic               adc_start, adc_done, ready;
    logic [10:0]        avg_count;
    logic [1:0]         adc_sel;
    logic [3:0]         lat;
    logic [15:0]        shunt_cal, adc_data, shunt_out, bus_out, temp_out;
    logic [15:0]        sv, bv, tv, seq;
    logic signed [15:0] current_out;
    logic signed [31:0] power_out;
    int                 fails, total_checks, cyc, starts, readies;
    int                 last_done, gap;

    pcacc_top pcacc_top_i (.clk(clk), .rst(rst), .run(run),
        .en_shunt(en_shunt), .en_bus(en_bus), .en_temp(en_temp),
        .avg_count(avg_count), .shunt_cal(shunt_cal), .adc_sel(adc_sel),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
        .current_out(current_out), .power_out(power_out),
        .shunt_out(shunt_out), .bus_out(bus_out), .temp_out(temp_out),
        .ready(ready));
    pcacc_adc_model pcacc_adc_model_i (.clk(clk), .rst(rst),
        .adc_sel(adc_sel), .adc_start(adc_start), .lat(lat),
        .shunt_v(sv), .bus_v(bv), .temp_v(tv), .adc_done(adc_done),
        .adc_data(adc_data));

    always #12.5 clk = ~clk;

    task automatic conclude;
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Logs converter starts, select order and result pulses
    always @(posedge clk)
    begin
        cyc++;
        if (adc_start === 1'b1)
        begin
            starts++;
            seq = {seq[13:0], adc_sel};
        end
        if (adc_done === 1'b1)
            last_done = cyc;
        if (ready === 1'b1)
        begin
            readies++;
            gap = cyc - last_done;
        end
        if (cyc > 20000)
        begin
            fails++;
            conclude();
        end
    end

    // One run pulse, then wait for the result pulse
    task automatic do_seq(input int n, input logic [15:0] order);
        int k;
        starts = 0;
        readies = 0;
        seq = 16'h0;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        k = 0;
        while (readies == 0 && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (6) @(posedge clk);
        check(32'(readies), 32'h1);
        check(32'(starts), 32'(n));
        check(32'(seq), 32'(order));
        check(32'(gap <= 8), 32'h1);
    endtask : do_seq

    task automatic s_all_once;
        {en_shunt, en_bus, en_temp} <= 3'b111;
        {avg_count, lat, shunt_cal} <= {11'h001, 4'h1, 16'h0020};
        {sv, bv, tv} <= {16'h1000, 16'h0200, 16'h0c80};
        do_seq(3, 16'h0006);
        check(32'(current_out), 32'h40);
        check(power_out, 32'h8000);
        check({shunt_out, bus_out}, 32'h1000_0200);
        check(32'(temp_out), 32'hc80);
    endtask : s_all_once

    task automatic s_negative_avg0;
        {avg_count, sv} <= {11'h000, 16'hf000};
        do_seq(3, 16'h0006);
        check(32'(current_out), 32'hffff_ffc0);
        check(power_out, 32'hffff_8000);
    endtask : s_negative_avg0

    task automatic s_zero_cal;
        {avg_count, lat, shunt_cal, sv} <= {11'h002, 4'h5, 16'h0, 16'h1000};
        do_seq(6, 16'h0186);
        check(power_out, 32'h0);
        check(32'(current_out), 32'h0);
    endtask : s_zero_cal

    task automatic s_avg_four;
        {en_temp, avg_count, lat} <= {1'b0, 11'h004, 4'h9};
        {shunt_cal, sv, bv} <= {16'h0040, 16'h0800, 16'h0300};
        do_seq(8, 16'h1111);
        check(32'(current_out), 32'h40);
        check(power_out, 32'hc000);
    endtask : s_avg_four

    task automatic s_shunt_only;
        {en_shunt, en_bus, en_temp, avg_count} <= {3'b100, 11'h001};
        sv <= 16'h0400;
        do_seq(1, 16'h0000);
        check(32'(shunt_out), 32'h0400);
        check(32'(current_out), 32'h0);
        check(power_out, 32'h0);
    endtask : s_shunt_only

    task automatic s_bus_temp;
        {en_shunt, en_bus, en_temp, lat} <= {3'b011, 4'h0};
        {bv, tv} <= {16'h0123, 16'h0456};
        do_seq(2, 16'h0006);
        check({bus_out, temp_out}, 32'h0123_0456);
        check(32'(current_out), 32'h0);
    endtask : s_bus_temp

    initial
    begin
        {clk, rst, run, en_shunt, en_bus, en_temp} = 6'b010000;
        {avg_count, shunt_cal, lat, sv, bv, tv} = '0;
        {fails, total_checks, cyc, starts, readies, last_done, gap} = '0;
        seq = 16'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({current_out, bus_out}, 32'h0);
        s_all_once();
        s_negative_avg0();
        s_zero_cal();
        s_avg_four();
        s_shunt_only();
        s_bus_temp();
        conclude();
    end
endmodule : pcacc_top_tb
